// ===== design/timer16_pkg.sv
// Package of constants and types for the 16-bit timer with capture.
`default_nettype none

package timer16_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_MODE     = 8'hc0;
    localparam logic [7:0] IDX_CNT_LO   = 8'hc1;
    localparam logic [7:0] IDX_CNT_HI   = 8'hc2;
    localparam logic [7:0] IDX_CAP_CTRL = 8'hc3;
    localparam logic [7:0] IDX_CAP_LO   = 8'hc4;
    localparam logic [7:0] IDX_CAP_HI   = 8'hc5;
    localparam logic [7:0] IDX_IRQ      = 8'hc6;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_ENABLE_BIT = 7;
    localparam int MODE_RATE_LSB   = 4;
    localparam int MODE_CLKSEL_BIT = 3;
    localparam int CAP_ENABLE_BIT  = 7;
    localparam int CAP_MODE_BIT    = 3;
    localparam int CAP_GO_BIT      = 2;
    localparam int CAP_FUNC_LSB    = 0;
    localparam int IRQ_FLAG_BIT    = 0;
    localparam int IRQ_EN_BIT      = 1;

    // ------------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------------
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [7:0]  CAP_CTRL_RST = 8'h00;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [15:0] COUNT_RST    = 16'h0000;
    localparam logic [15:0] COUNT_FULL   = 16'hffff;
    localparam logic [6:0]  PRESC_MASK   = 7'h7f;

    // ------------------------------------------------------------------
    // Capture functions
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FUNC_ACCUM,
        FUNC_HIGH,
        FUNC_LOW,
        FUNC_CYCLE
    } cap_func_t;

    // True when the bus address selects the register with the given index.
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [7:0]        idx);
        addr_hit = (addr == {2'b00, idx, 2'b00});
    endfunction : addr_hit

endpackage : timer16_pkg

`default_nettype wire

// ===== design/timer_evt_if.sv
// Interface carrying timer ticks and input edges to the timer core.
`default_nettype none

interface timer_evt_if;
    logic tick;
    logic rise;
    logic fall;

    modport presc_mp (output tick);
    modport edge_mp  (output rise, output fall);
    modport core_mp  (input tick, input rise, input fall);
endinterface : timer_evt_if

`default_nettype wire

// ===== design/timer_prescaler.sv
// Prescaler that turns the selected source tick into the timer tick.
`default_nettype none

module timer_prescaler (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           run,
    input  wire logic           src_tick,
    input  wire logic [2:0]     rate,
    timer_evt_if.presc_mp       evt
);
    logic [6:0] div_r;
    logic [6:0] mask;

    // Divider restarts while the timer is stopped so the first period is whole.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 7'h00;
        end else if (!run) begin
            div_r <= 7'h00;
        end else if (src_tick) begin
            div_r <= div_r + 7'h01;
        end
    end

    assign mask     = timer16_pkg::PRESC_MASK >> rate;  // see R8
    assign evt.tick = run & src_tick & ((div_r & mask) == mask);  // see R8

endmodule : timer_prescaler

`default_nettype wire

// ===== design/capture_edge.sv
// Synchroniser and edge detector for the capture input pin.
`default_nettype none

module capture_edge (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           pin,
    timer_evt_if.edge_mp        evt
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;

    // Two flops absorb metastability; only the second and third are compared.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= pin;  // see R22
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign evt.rise = sync2_r & ~prev_r;  // see R22
    assign evt.fall = ~sync2_r & prev_r;  // see R22

endmodule : capture_edge

`default_nettype wire

// ===== design/timer16_with_capture.sv
// Top of the 16-bit timer with capture front-end and APB register slave.
//
// The APB interface to the registers was left to the implementer.
`default_nettype none

// How it works
// R1: Enable bit halts or runs main counter.
// R2: Counter steps once per prescaled tick.
// R3: Wrap to zero sets sticky overflow flag.
// R4: No reload; counter continues from zero.
// R5: Flag with enable raises interrupt request.
// R6: Software clears flag; no auto clear.
// R7: Clock select picks instruction or oscillator tick.
// R8: Prescale code divides 128 down to 1.
// R9: Runs in any power mode, no wake.
// R10: High byte held, low write loads all.
// R11: Low read snapshots high half for later.
// R12: Software preloads 65536 minus interval.
// R13: Software configures before enabling timer.
// R14: Capture active only with both enables.
// R15: Function field selects capture behaviour.
// R16: Accumulative counts input edges only.
// R17: Go waits trigger edge, then counts.
// R18: Second edge stops, clears go, sets flag.
// R19: Timer and capture share flag, request.
// R20: Edge pairs per pulse and cycle mode.
// R21: Accumulative ends on chosen counter wrap.
// R22: Input synchronised before edge detection.
module timer16_with_capture (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [timer16_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [timer16_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic      [timer16_pkg::DATA_W-1:0]   prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             instr_tick,
    input  wire logic                             hosc_tick,
    input  wire logic                             capture_input_pin,
    output logic                                  irq_req
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CAP_IDLE,
        CAP_ARMED,
        CAP_COUNT
    } cap_state_t;

    cap_state_t             state_r;
    cap_state_t             state_nxt;

    logic                   timer_enable;
    logic [2:0]             prescale_select;
    logic                   clock_select;
    logic [4:0]             mode_bits_r;

    logic                   capture_enable_r;
    logic                   capture_mode_select_r;
    logic                   capture_go_r;
    timer16_pkg::cap_func_t capture_function_select_r;

    logic [15:0]            count_r;
    logic [7:0]             cnt_hi_wr_r;
    logic [7:0]             cnt_hi_rd_r;
    logic [15:0]            cap_cnt_r;
    logic [7:0]             cap_hi_wr_r;
    logic [7:0]             cap_hi_rd_r;

    logic                   overflow_flag_r;
    logic                   overflow_irq_enable_r;

    logic [7:0]             rd_byte;
    logic                   mapped;
    logic                   setup_ph;
    logic                   wr_ok;
    logic                   rd_setup;
    logic [7:0]             wbyte;

    logic                   src_tick;
    logic                   cap_active;
    logic                   measuring;
    logic                   main_step;
    logic                   main_wrap;
    logic                   cap_step;
    logic                   cap_wrap;
    logic                   start_edge;
    logic                   stop_hit;
    logic                   cap_done;

    timer_evt_if            evt ();

    // ------------------------------------------------------------------
    // Time base and input front-end
    // ------------------------------------------------------------------
    assign timer_enable    = mode_bits_r[4];
    assign prescale_select = mode_bits_r[3:1];
    assign clock_select    = mode_bits_r[0];
    assign src_tick        = clock_select ? hosc_tick : instr_tick;  // see R7

    timer_prescaler u_presc (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (timer_enable),
        .src_tick (src_tick),
        .rate     (prescale_select),
        .evt      (evt.presc_mp)
    );

    capture_edge u_edge (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (capture_input_pin),
        .evt   (evt.edge_mp)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Zero wait states: every transfer is one setup and one access cycle.
    assign pready   = 1'b1;
    assign setup_ph = psel & ~penable;
    assign rd_setup = setup_ph & ~pwrite;
    assign wbyte    = pwdata[7:0];

    always_comb begin
        mapped = timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_MODE)
               | timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CNT_LO)
               | timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CNT_HI)
               | timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_CTRL)
               | timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_LO)
               | timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_HI)
               | timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_IRQ);
    end

    assign pslverr = psel & penable & ~mapped;
    assign wr_ok   = psel & penable & pwrite & pstrb[0] & mapped;

    // ------------------------------------------------------------------
    // Capture sequencing conditions
    // ------------------------------------------------------------------
    assign cap_active = timer_enable & capture_enable_r;  // see R14
    assign measuring  = (state_r == CAP_COUNT);

    // No power-mode gating: counting continues in green mode and no wake
    // request leaves the block.
    assign main_step = timer_enable & evt.tick & (~cap_active | measuring);  // see R1 R2 R9
    assign main_wrap = main_step & (count_r == timer16_pkg::COUNT_FULL);  // see R3

    // The accumulative counter advances on rising input edges, never on the tick.
    assign cap_step = measuring & (capture_function_select_r == timer16_pkg::FUNC_ACCUM)
                    & evt.rise;  // see R16
    assign cap_wrap = cap_step & (cap_cnt_r == timer16_pkg::COUNT_FULL);

    always_comb begin
        start_edge = evt.rise;
        stop_hit   = 1'b0;
        unique case (capture_function_select_r)
            timer16_pkg::FUNC_ACCUM: begin
                stop_hit = capture_mode_select_r ? main_wrap : cap_wrap;  // see R21
            end
            timer16_pkg::FUNC_HIGH: begin
                stop_hit = evt.fall;  // see R20
            end
            timer16_pkg::FUNC_LOW: begin
                start_edge = evt.fall;  // see R20
                stop_hit   = evt.rise;
            end
            timer16_pkg::FUNC_CYCLE: begin
                stop_hit = evt.rise;  // see R20
            end
        endcase
    end

    assign cap_done = measuring & cap_active & capture_go_r & stop_hit;  // see R18

    // ------------------------------------------------------------------
    // Capture state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CAP_IDLE: begin
                if (cap_active && capture_go_r) begin
                    state_nxt = CAP_ARMED;  // see R17
                end
            end
            CAP_ARMED: begin
                if (!cap_active || !capture_go_r) begin
                    state_nxt = CAP_IDLE;
                end else if (start_edge) begin
                    state_nxt = CAP_COUNT;  // see R17
                end
            end
            CAP_COUNT: begin
                if (!cap_active || !capture_go_r || cap_done) begin
                    state_nxt = CAP_IDLE;  // see R18
                end
            end
            default: begin
                state_nxt = CAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CAP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_bits_r <= timer16_pkg::MODE_RST[7:3];
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_MODE)) begin
            mode_bits_r <= wbyte[timer16_pkg::MODE_ENABLE_BIT:timer16_pkg::MODE_CLKSEL_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Capture control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_enable_r          <= timer16_pkg::CAP_CTRL_RST[timer16_pkg::CAP_ENABLE_BIT];
            capture_mode_select_r     <= timer16_pkg::CAP_CTRL_RST[timer16_pkg::CAP_MODE_BIT];
            capture_function_select_r <= timer16_pkg::FUNC_ACCUM;
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_CTRL)) begin
            capture_enable_r          <= wbyte[timer16_pkg::CAP_ENABLE_BIT];
            capture_mode_select_r     <= wbyte[timer16_pkg::CAP_MODE_BIT];
            capture_function_select_r <= timer16_pkg::cap_func_t'(
                wbyte[timer16_pkg::CAP_FUNC_LSB +: 2]);  // see R15
        end
    end

    // A software write in the same cycle as completion wins, so a fresh
    // start request is never dropped.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_go_r <= timer16_pkg::CAP_CTRL_RST[timer16_pkg::CAP_GO_BIT];
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_CTRL)) begin
            capture_go_r <= wbyte[timer16_pkg::CAP_GO_BIT];
        end else if (cap_done) begin
            capture_go_r <= 1'b0;  // see R18
        end
    end

    // ------------------------------------------------------------------
    // Main counter and its byte latches
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_hi_wr_r <= timer16_pkg::BYTE_RST;
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CNT_HI)) begin
            cnt_hi_wr_r <= wbyte;  // see R10
        end
    end

    // Without a reload buffer the counter simply rolls over to zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= timer16_pkg::COUNT_RST;
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CNT_LO)) begin
            count_r <= {cnt_hi_wr_r, wbyte};  // see R10
        end else if (main_step) begin
            count_r <= count_r + 16'h0001;  // see R2 R4
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_hi_rd_r <= timer16_pkg::BYTE_RST;
        end else if (rd_setup && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CNT_LO)) begin
            cnt_hi_rd_r <= count_r[15:8];  // see R11
        end
    end

    // ------------------------------------------------------------------
    // Capture counter and its byte latches
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_hi_wr_r <= timer16_pkg::BYTE_RST;
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_HI)) begin
            cap_hi_wr_r <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt_r <= timer16_pkg::COUNT_RST;
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_LO)) begin
            cap_cnt_r <= {cap_hi_wr_r, wbyte};
        end else if (cap_step) begin
            cap_cnt_r <= cap_cnt_r + 16'h0001;  // see R16
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_hi_rd_r <= timer16_pkg::BYTE_RST;
        end else if (rd_setup && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_LO)) begin
            cap_hi_rd_r <= cap_cnt_r[15:8];
        end
    end

    // ------------------------------------------------------------------
    // Overflow flag and interrupt request
    // ------------------------------------------------------------------
    // The flag is never cleared by the interrupt being taken; only a write
    // of zero clears it, and a same-cycle event keeps it set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag_r <= 1'b0;
        end else if (main_wrap || cap_done) begin
            overflow_flag_r <= 1'b1;  // see R3 R18 R19
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_IRQ)
                     && !wbyte[timer16_pkg::IRQ_FLAG_BIT]) begin
            overflow_flag_r <= 1'b0;  // see R6
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_irq_enable_r <= 1'b0;
        end else if (wr_ok && timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_IRQ)) begin
            overflow_irq_enable_r <= wbyte[timer16_pkg::IRQ_EN_BIT];
        end
    end

    assign irq_req = overflow_flag_r & overflow_irq_enable_r;  // see R5 R19

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_MODE)) begin
            rd_byte = {mode_bits_r, 3'b000};
        end else if (timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CNT_LO)) begin
            rd_byte = count_r[7:0];
        end else if (timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CNT_HI)) begin
            rd_byte = cnt_hi_rd_r;  // see R11
        end else if (timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_CTRL)) begin
            rd_byte = {capture_enable_r, 3'b000, capture_mode_select_r, capture_go_r,
                       capture_function_select_r};
        end else if (timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_LO)) begin
            rd_byte = cap_cnt_r[7:0];
        end else if (timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_CAP_HI)) begin
            rd_byte = cap_hi_rd_r;
        end else if (timer16_pkg::addr_hit(paddr, timer16_pkg::IDX_IRQ)) begin
            rd_byte = {6'b00_0000, overflow_irq_enable_r, overflow_flag_r};
        end
    end

    // Read data is captured at the end of the setup cycle and stands
    // through the access cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule : timer16_with_capture

`default_nettype wire

// ===== verification/pulse_src.sv
// Pulse source that drives the capture input pin with a fixed high and low time.
`default_nettype none
module pulse_src #(
    parameter int HI = 40,
    parameter int LO = 30
) (
    input  wire logic clk,
    input  wire logic run,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;

    // The pin rests low while the source is stopped.
    always @(posedge clk) begin
        if (!run) begin
            pin <= 1'b0;
            n   <= 0;
        end else begin
            n   <= (n == HI + LO - 1) ? 0 : n + 1;
            pin <= (n < HI);
        end
    end
endmodule : pulse_src
`default_nettype wire

// ===== verification/timer16_asserts.sv
// Checker of the timer's bus answers and flag behaviour, bound to the top module.
`default_nettype none
module timer16_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire  acc = psel && penable;
    wire  map = paddr >= 12'h300 && paddr <= 12'h318 && paddr[1:0] == 2'b00;
    wire  wr6 = acc && pwrite && paddr == 12'h318;
    wire  rd  = acc && !pwrite;
    logic en_r;

    // Mirror of the timer enable bit as last written by software.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 1'b0;
        end else if (acc && pwrite && paddr == 12'h300) begin
            en_r <= pwdata[7];
        end
    end

    AST_READY: assert property (pready) else $error("pready low");
    AST_ERR_MAP: assert property (acc && !map |-> pslverr) else $error("no slave error");
    AST_ERR_ONLY: assert property (pslverr |-> acc && !map) else $error("stray slave error");
    AST_RD_UPPER: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    AST_UNMAP_RD0: assert property (rd && !map |-> prdata == 32'h0) else $error("unmapped data");
    AST_MODE_RD: assert property (rd && paddr == 12'h300 |->
        prdata[7] == en_r && prdata[2:0] == 3'b000) else $error("mode readback wrong");
    AST_IRQ_STICKY: assert property ($fell(irq_req) |-> $past(wr6))
        else $error("flag cleared without software");
    AST_IRQ_HALT: assert property ($rose(irq_req) |-> $past(en_r) || $past(wr6))
        else $error("flag set while halted");
    COV_IRQ: cover property ($rose(irq_req));
    COV_CLR: cover property ($fell(irq_req));
    COV_ERR: cover property (pslverr);
endmodule : timer16_asserts

bind timer16_with_capture timer16_asserts chk_i (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_req);
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking testbench for the 16-bit timer with capture.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_req;
    logic        instr_tick, hosc_tick, pin, run, ph, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    int          error_cnt, samples_checked, n, ex, v;

    timer16_with_capture dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .instr_tick, .hosc_tick,
        .capture_input_pin(pin), .irq_req);
    pulse_src src (.clk, .run, .pin);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Instruction ticks come every cycle, oscillator ticks every second cycle.
    always @(posedge clk) begin
        ph         <= rst_n & ~ph;
        instr_tick <= rst_n;
        hosc_tick  <= rst_n & ph;
    end

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task wait_irq;
        n = 0;
        while (irq_req !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_irq
    task test_done;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    initial begin
        #800_000;
        error_cnt++;
        test_done();
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, run} = '0;
        pstrb = 4'hf;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(12'h300 + 4 * i), 32'h0);
            chk("reset value", rdat, 32'h0);
            chk("reset error", err, 1'b0);
        end
        apb(1'b0, 12'h400, 32'h0);
        chk("unmapped error", err, 1'b1);
        apb(1'b1, 12'h308, 8'h12);
        apb(1'b1, 12'h304, 8'h34);
        apb(1'b1, 12'h308, 8'h56);
        apb(1'b0, 12'h304, 32'h0);
        chk("count low", rdat, 8'h34);
        apb(1'b0, 12'h308, 32'h0);
        chk("count high", rdat, 8'h12);
        pstrb <= 4'h0;
        apb(1'b1, 12'h318, 8'h02);
        pstrb <= 4'hf;
        apb(1'b0, 12'h318, 32'h0);
        chk("masked write", rdat, 32'h0);
        // ------------------------------------------------------------
        // Overflow time for every prescale code, odd codes on the oscillator tick.
        // ------------------------------------------------------------
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, 12'h308, 8'hff);
            apb(1'b1, 12'h304, 8'hff);
            apb(1'b1, 12'h318, 8'h02);
            apb(1'b1, 12'h300, {24'h0, 1'b1, 3'(r), r[0], 3'b000});
            wait_irq();
            ex = (128 >> r) * (1 + r % 2);
            chk("overflow time", n >= ex - 2 && n <= ex + 6, 1'b1);
            repeat (8) @(negedge clk);
            chk("flag sticky", irq_req, 1'b1);
            apb(1'b1, 12'h300, 8'h00);
            apb(1'b0, 12'h304, 32'h0);
            apb(1'b0, 12'h308, 32'h0);
            chk("count after wrap", rdat, 32'h0);
            apb(1'b1, 12'h318, 8'h02);
            @(negedge clk);
            chk("flag cleared", irq_req, 1'b0);
        end
        run <= 1'b1;
        // Pulse, low and cycle measurement, then accumulative capture in both end modes.
        for (int f = 1; f < 6; f++) begin
            apb(1'b1, 12'h314, 8'hff);
            apb(1'b1, 12'h310, 8'hfd);
            apb(1'b1, 12'h308, f == 5 ? 8'hff : 8'h00);
            apb(1'b1, 12'h304, f == 5 ? 8'h80 : 8'h00);
            apb(1'b1, 12'h318, 8'h02);
            apb(1'b1, 12'h30c, f == 5 ? 8'h88 : 8'h80 | 2'(f));
            apb(1'b1, 12'h300, 8'hf0);
            apb(1'b1, 12'h30c, f == 5 ? 8'h8c : 8'h84 | 2'(f));
            wait_irq();
            chk("capture done", irq_req, 1'b1);
            apb(1'b0, 12'h30c, 32'h0);
            chk("go cleared", rdat[2], 1'b0);
            apb(1'b0, f > 3 ? 12'h310 : 12'h304, 32'h0);
            v = rdat[7:0];
            apb(1'b0, f > 3 ? 12'h314 : 12'h308, 32'h0);
            v = v + 256 * rdat[7:0];
            ex = f == 5 ? 65534 : f == 4 ? 0 : f == 1 ? 40 : f == 2 ? 30 : 70;
            chk("measured", v >= ex - 2 && v <= ex + 2, 1'b1);
            apb(1'b1, 12'h300, 8'h00);
            apb(1'b1, 12'h30c, 8'h00);
        end
        test_done();
    end
endmodule : tb_top
`default_nettype wire
